// File: inc/esm_map.vh
// Register map, bit positions, reset values and timing counts of the event status block
`ifndef ESM_MAP_VH
`define ESM_MAP_VH

// Byte offsets on the parallel control port
`define ESM_OFS_STATUS_ONE     8'h20
`define ESM_OFS_STATUS_TWO     8'h21
`define ESM_OFS_LCV_HIGH       8'h23
`define ESM_OFS_LCV_LOW        8'h24
`define ESM_OFS_MASK_TWO       8'h6f
`define ESM_OFS_MASK_ONE       8'h7f

// Bank one bit positions
`define ESM_B1_LOOP_UP         7
`define ESM_B1_LOOP_DOWN       6
`define ESM_B1_TX_CLK_LOST     5
`define ESM_B1_SLIP            4
`define ESM_B1_BLUE            3
`define ESM_B1_YELLOW          2
`define ESM_B1_CARRIER_LOSS    1
`define ESM_B1_SYNC_LOSS       0

// Bank two bit positions
`define ESM_B2_RX_MF           7
`define ESM_B2_TX_MF           6
`define ESM_B2_ONE_SEC         5
`define ESM_B2_RX_LINK_FULL    4
`define ESM_B2_TX_LINK_EMPTY   3
`define ESM_B2_RX_LINK_MATCH   2
`define ESM_B2_RX_LINK_ABORT   1
`define ESM_B2_RX_SIG_CHANGE   0

// Reset values
`define ESM_RST_MASK           8'h00
`define ESM_RST_STATUS         8'h00
`define ESM_RST_COUNT          16'h0000

// Timing, counted in recovered receive bit clocks
`define ESM_RX_BITS_PER_MS     1544
`define ESM_SEC_SHORT_MS       999
`define ESM_SEC_LONG_MS        1002
`define ESM_FAST_INTERVAL_MS   42
`define ESM_BLUE_WINDOW_MS     3
`define ESM_BLUE_SET_ZEROS     5
`define ESM_LINK_ABORT_ONES    8
`define ESM_ZERO_RUN_PLAIN     16
`define ESM_ZERO_RUN_B8ZS      8

`endif

// File: logic/esm_lcv_detect.v
// Line code violation detector: bipolar violations, B8ZS words and excessive zeros
`timescale 1ns/100ps
`include "esm_map.vh"

module esm_lcv_detect (
  input  wire clk_i,
  input  wire rst_i,
  input  wire bit_en_i,
  input  wire pos_i,
  input  wire neg_i,
  input  wire b8zs_en_i,
  input  wire count_zeros_i,
  output reg  viol_o
);

  reg  [7:0] hist_pos_q;
  reg  [7:0] hist_neg_q;
  reg  [7:0] bpv_q;
  reg        last_pos_q;
  reg        mark_seen_q;
  reg  [4:0] zero_run_q;

  wire       mark      = pos_i ^ neg_i;
  wire       bpv_now   = mark & mark_seen_q & (pos_i == last_pos_q);
  wire [7:0] next_pos  = {hist_pos_q[6:0], pos_i & ~neg_i};
  wire [7:0] next_neg  = {hist_neg_q[6:0], neg_i & ~pos_i};
  wire [7:0] empty     = ~(next_pos | next_neg);
  // Pattern 000VB0VB, newest symbol at index 0
  wire       code_word = b8zs_en_i & empty[7] & empty[6] & empty[5] & empty[2] &
                         ((next_pos[4] & next_pos[0] & next_neg[3] & next_neg[1]) |
                          (next_neg[4] & next_neg[0] & next_pos[3] & next_pos[1]));
  // Violations are held eight symbols so a completed code word can withdraw its two V bits
  wire [7:0] next_bpv  = {bpv_q[6:0], bpv_now} & ~(code_word ? 8'h12 : 8'h00); // R15
  wire [4:0] zero_lim  = b8zs_en_i ? 5'd`ESM_ZERO_RUN_B8ZS : 5'd`ESM_ZERO_RUN_PLAIN;
  wire [4:0] zero_inc  = zero_run_q + 5'h01;
  wire       zero_hit  = count_zeros_i & ~mark & (zero_inc == zero_lim); // R19

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hist_pos_q  <= 8'h00;
      hist_neg_q  <= 8'h00;
      bpv_q       <= 8'h00;
      last_pos_q  <= 1'b0;
      mark_seen_q <= 1'b0;
      zero_run_q  <= 5'h00;
      viol_o      <= 1'b0;
    end
    else
    begin
      viol_o <= bit_en_i & (bpv_q[7] | zero_hit); // R15
      if (bit_en_i)
      begin
        hist_pos_q <= next_pos;
        hist_neg_q <= next_neg;
        bpv_q      <= next_bpv;
        if (mark)
        begin
          last_pos_q  <= pos_i;
          mark_seen_q <= 1'b1;
          zero_run_q  <= 5'h00;
        end
        else if (zero_run_q != zero_lim)
          zero_run_q <= zero_inc;
      end
    end
  end

endmodule

// File: logic/esm_core.v
// Event status banks, interrupt masks, one-second timer and line code violation counter
//
// Notes on behaviour
// R1: Receive multiframe boundary sets its bank-two flag
// R2: Transmit multiframe boundary sets its bank-two flag
// R3: One-second flag spaced 999, 999, 1002 ms
// R4: Full receive link byte sets buffer-full flag
// R5: Transmit link buffer emptied sets its flag
// R6: Received link byte matching either value flags
// R7: Eight consecutive link ones set abort flag
// R8: Any signaling bit change sets change flag
// R9: Mask one bits gate bank-one interrupts, 1 enables
// R10: Mask two bits gate bank-two interrupts, 1 enables
// R11: Counters update each second, or every 42 ms
// R12: Counters show previous interval; host reads in time
// R13: Counters saturate at maximum, never wrap
// R14: Violation counter 16 bits, high 0x23, low 0x24
// R15: Count BPVs and zeros, skip B8ZS words
// R16: Violation counter runs even during sync loss
// R17: Blue alarm robust to errors, ignores framed ones
// R18: Host should qualify blue alarm with sync loss
// R19: Excess zeros are 16, or 8 with B8ZS
// R20: Sync loss flag set while framer unsynchronized
// R21: Interrupt high while any enabled flag set
`timescale 1ns/100ps
`include "esm_map.vh"

module esm_core #(
  parameter SIG_W        = 48,
  parameter SEC_W        = 21,
  parameter SEC_SHORT    = `ESM_SEC_SHORT_MS * `ESM_RX_BITS_PER_MS,
  parameter SEC_LONG     = `ESM_SEC_LONG_MS * `ESM_RX_BITS_PER_MS,
  parameter FAST_W       = 17,
  parameter FAST_BITS    = `ESM_FAST_INTERVAL_MS * `ESM_RX_BITS_PER_MS,
  parameter BLUE_W       = 13,
  parameter BLUE_BITS    = `ESM_BLUE_WINDOW_MS * `ESM_RX_BITS_PER_MS
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [7:0]       addr_i,
  input  wire [7:0]       wdata_i,
  input  wire             wr_i,
  input  wire             rd_i,
  output wire [7:0]       rdata_o,
  input  wire             rx_bit_en_i,
  input  wire             rx_pos_i,
  input  wire             rx_neg_i,
  input  wire             b8zs_en_i,
  input  wire             count_zeros_i,
  input  wire             interval_42ms_i,
  input  wire             rx_multiframe_i,
  input  wire             tx_multiframe_i,
  input  wire             rx_link_bit_en_i,
  input  wire             rx_link_bit_i,
  input  wire [7:0]       link_match_value_one_i,
  input  wire [7:0]       link_match_value_two_i,
  input  wire             tx_link_empty_i,
  input  wire             rx_sig_valid_i,
  input  wire [SIG_W-1:0] rx_sig_bits_i,
  input  wire             loop_up_detected_i,
  input  wire             loop_down_detected_i,
  input  wire             tx_clock_lost_i,
  input  wire             rx_slip_i,
  input  wire             rx_yellow_alarm_i,
  input  wire             line_carrier_loss_i,
  input  wire             rx_sync_loss_i,
  output wire             rx_blue_alarm_o,
  output wire             one_second_tick_o,
  output wire             int_o
);

  localparam [SEC_W-1:0]  SEC_SHORT_END = SEC_SHORT - 1;
  localparam [SEC_W-1:0]  SEC_LONG_END  = SEC_LONG - 1;
  localparam [FAST_W-1:0] FAST_END      = FAST_BITS - 1;
  localparam [BLUE_W-1:0] BLUE_END      = BLUE_BITS - 1;
  localparam [1:0]        PH_FIRST      = 2'd0;
  localparam [1:0]        PH_SECOND     = 2'd1;
  localparam [1:0]        PH_LONG       = 2'd2;

  reg  [7:0]        mask_one_q;
  reg  [7:0]        mask_two_q;
  reg  [15:0]       flag_q;
  reg  [7:0]        rdata_q;
  reg  [7:0]        rdata_d;
  reg               int_q;
  reg  [SEC_W-1:0]  sec_cnt_q;
  reg  [1:0]        sec_phase_q;
  reg               sec_tick_q;
  reg  [FAST_W-1:0] fast_cnt_q;
  reg  [BLUE_W-1:0] blue_cnt_q;
  reg  [2:0]        blue_zeros_q;
  reg               blue_q;
  reg  [7:0]        link_shift_q;
  reg  [2:0]        link_bits_q;
  reg  [3:0]        link_ones_q;
  reg               link_full_q;
  reg               link_match_q;
  reg               link_abort_q;
  reg  [SIG_W-1:0]  sig_prev_q;
  reg               sig_seen_q;
  reg               sig_change_q;
  reg  [15:0]       lcv_acc_q;
  reg  [15:0]       lcv_q;

  wire              lcv_viol;
  wire [15:0]       flag_set;
  wire [15:0]       flag_clr;
  wire              rd_one = rd_i & (addr_i == `ESM_OFS_STATUS_ONE);
  wire              rd_two = rd_i & (addr_i == `ESM_OFS_STATUS_TWO);
  wire              wr_m1  = wr_i & (addr_i == `ESM_OFS_MASK_ONE);
  wire              wr_m2  = wr_i & (addr_i == `ESM_OFS_MASK_TWO);

  // One-second timer on the recovered receive clock
  wire [SEC_W-1:0]  sec_end  = (sec_phase_q == PH_LONG) ? SEC_LONG_END : SEC_SHORT_END;
  wire              sec_tick = rx_bit_en_i & (sec_cnt_q == sec_end); // R3
  wire              fast_tick = rx_bit_en_i & (fast_cnt_q == FAST_END);
  wire              update    = interval_42ms_i ? fast_tick : sec_tick; // R11

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sec_cnt_q   <= {SEC_W{1'b0}};
      sec_phase_q <= PH_FIRST;
      sec_tick_q  <= 1'b0;
      fast_cnt_q  <= {FAST_W{1'b0}};
    end
    else
    begin
      sec_tick_q <= sec_tick;
      if (rx_bit_en_i)
      begin
        fast_cnt_q <= fast_tick ? {FAST_W{1'b0}} : fast_cnt_q + 1'b1;
        if (sec_tick)
        begin
          sec_cnt_q <= {SEC_W{1'b0}};
          case (sec_phase_q)
            PH_FIRST:  sec_phase_q <= PH_SECOND;
            PH_SECOND: sec_phase_q <= PH_LONG;
            default:   sec_phase_q <= PH_FIRST;
          endcase
        end
        else
          sec_cnt_q <= sec_cnt_q + 1'b1;
      end
    end
  end

  // Blue alarm: few zeros over a 3 ms window; framing bits of an all-ones
  // framed signal give far more zeros than the set threshold
  wire       rx_zero       = ~(rx_pos_i | rx_neg_i);
  wire [2:0] blue_zeros_n  = (rx_zero && blue_zeros_q != 3'h7) ?
                             blue_zeros_q + 3'h1 : blue_zeros_q;
  wire       blue_win_end  = rx_bit_en_i & (blue_cnt_q == BLUE_END);

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blue_cnt_q   <= {BLUE_W{1'b0}};
      blue_zeros_q <= 3'h0;
      blue_q       <= 1'b0;
    end
    else if (rx_bit_en_i)
    begin
      if (blue_win_end)
      begin
        blue_cnt_q   <= {BLUE_W{1'b0}};
        blue_zeros_q <= 3'h0;
        blue_q       <= (blue_zeros_n <= 3'd`ESM_BLUE_SET_ZEROS); // R17
      end
      else
      begin
        blue_cnt_q   <= blue_cnt_q + 1'b1;
        blue_zeros_q <= blue_zeros_n;
      end
    end
  end

  // Receive data link byte assembly, match and abort detection
  wire [7:0] link_byte = {link_shift_q[6:0], rx_link_bit_i};
  wire       link_done = rx_link_bit_en_i & (link_bits_q == 3'h7);

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link_shift_q <= 8'h00;
      link_bits_q  <= 3'h0;
      link_ones_q  <= 4'h0;
      link_full_q  <= 1'b0;
      link_match_q <= 1'b0;
      link_abort_q <= 1'b0;
    end
    else
    begin
      link_full_q  <= link_done; // R4
      link_match_q <= link_done & ((link_byte == link_match_value_one_i) |
                                   (link_byte == link_match_value_two_i)); // R6
      link_abort_q <= rx_link_bit_en_i & rx_link_bit_i &
                      (link_ones_q == 4'd`ESM_LINK_ABORT_ONES - 4'd1); // R7
      if (rx_link_bit_en_i)
      begin
        link_shift_q <= link_byte;
        link_bits_q  <= link_bits_q + 3'h1;
        if (!rx_link_bit_i)
          link_ones_q <= 4'h0;
        else if (link_ones_q != 4'd`ESM_LINK_ABORT_ONES)
          link_ones_q <= link_ones_q + 4'h1;
      end
    end
  end

  // Signaling change; the first sample after reset only primes the history
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sig_prev_q   <= {SIG_W{1'b0}};
      sig_seen_q   <= 1'b0;
      sig_change_q <= 1'b0;
    end
    else
    begin
      sig_change_q <= rx_sig_valid_i & sig_seen_q & (rx_sig_bits_i != sig_prev_q); // R8
      if (rx_sig_valid_i)
      begin
        sig_prev_q <= rx_sig_bits_i;
        sig_seen_q <= 1'b1;
      end
    end
  end

  // Line code violations, never gated by sync loss
  esm_lcv_detect u_lcv (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .bit_en_i      (rx_bit_en_i),
    .pos_i         (rx_pos_i),
    .neg_i         (rx_neg_i),
    .b8zs_en_i     (b8zs_en_i),
    .count_zeros_i (count_zeros_i),
    .viol_o        (lcv_viol)
  );

  wire [15:0] lcv_next = (lcv_viol && lcv_acc_q != 16'hffff) ? lcv_acc_q + 16'h0001
                                                             : lcv_acc_q; // R13

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lcv_acc_q <= `ESM_RST_COUNT;
      lcv_q     <= `ESM_RST_COUNT;
    end
    else if (update)
    begin
      // Snapshot is replaced every interval, unread data is lost
      lcv_q     <= lcv_next; // R12
      lcv_acc_q <= `ESM_RST_COUNT;
    end
    else
      lcv_acc_q <= lcv_next; // R16
  end

  // Sticky flags, cleared by reading their bank; a set in the read cycle wins
  assign flag_set[`ESM_B1_LOOP_UP]            = loop_up_detected_i;
  assign flag_set[`ESM_B1_LOOP_DOWN]          = loop_down_detected_i;
  assign flag_set[`ESM_B1_TX_CLK_LOST]        = tx_clock_lost_i;
  assign flag_set[`ESM_B1_SLIP]               = rx_slip_i;
  assign flag_set[`ESM_B1_BLUE]               = blue_q;
  assign flag_set[`ESM_B1_YELLOW]             = rx_yellow_alarm_i;
  assign flag_set[`ESM_B1_CARRIER_LOSS]       = line_carrier_loss_i;
  assign flag_set[`ESM_B1_SYNC_LOSS]          = rx_sync_loss_i; // R20
  assign flag_set[8+`ESM_B2_RX_MF]            = rx_multiframe_i; // R1
  assign flag_set[8+`ESM_B2_TX_MF]            = tx_multiframe_i; // R2
  assign flag_set[8+`ESM_B2_ONE_SEC]          = sec_tick_q; // R3
  assign flag_set[8+`ESM_B2_RX_LINK_FULL]     = link_full_q; // R4
  assign flag_set[8+`ESM_B2_TX_LINK_EMPTY]    = tx_link_empty_i; // R5
  assign flag_set[8+`ESM_B2_RX_LINK_MATCH]    = link_match_q; // R6
  assign flag_set[8+`ESM_B2_RX_LINK_ABORT]    = link_abort_q; // R7
  assign flag_set[8+`ESM_B2_RX_SIG_CHANGE]    = sig_change_q; // R8
  assign flag_clr = {{8{rd_two}}, {8{rd_one}}};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_flag
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          flag_q[gi] <= 1'b0;
        else
          flag_q[gi] <= (flag_q[gi] & ~flag_clr[gi]) | flag_set[gi];
      end
    end
  endgenerate

  // Registers: masks, read data, interrupt
  always @*
  begin
    rdata_d = 8'h00;
    if (addr_i == `ESM_OFS_STATUS_ONE)
      rdata_d = flag_q[7:0];
    else if (addr_i == `ESM_OFS_STATUS_TWO)
      rdata_d = flag_q[15:8];
    else if (addr_i == `ESM_OFS_LCV_HIGH)
      rdata_d = lcv_q[15:8]; // R14
    else if (addr_i == `ESM_OFS_LCV_LOW)
      rdata_d = lcv_q[7:0]; // R14
    else if (addr_i == `ESM_OFS_MASK_TWO)
      rdata_d = mask_two_q;
    else if (addr_i == `ESM_OFS_MASK_ONE)
      rdata_d = mask_one_q;
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mask_one_q <= `ESM_RST_MASK;
      mask_two_q <= `ESM_RST_MASK;
      rdata_q    <= 8'h00;
      int_q      <= 1'b0;
    end
    else
    begin
      if (wr_m1)
        mask_one_q <= wdata_i;
      if (wr_m2)
        mask_two_q <= wdata_i;
      if (rd_i)
        rdata_q <= rdata_d;
      // Mask bit 1 passes its flag to the interrupt line
      int_q <= (|(flag_q[7:0] & mask_one_q)) | (|(flag_q[15:8] & mask_two_q)); // R9 R10 R21
    end
  end

  assign rdata_o           = rdata_q;
  assign int_o             = int_q;
  assign rx_blue_alarm_o   = blue_q;
  assign one_second_tick_o = sec_tick_q;

endmodule

// File: bench/esm_chk.sv
// Port assertions for the event status block
`timescale 1ns/100ps
module esm_chk #(
  parameter SEC_SHORT = 30,
  parameter SEC_LONG  = 33
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       rx_bit_en_i,
  input wire       rx_multiframe_i,
  input wire       rx_sync_loss_i,
  input wire       one_second_tick_o,
  input wire       int_o
);
  reg [7:0]  m1_q;
  reg [7:0]  m2_q;
  reg [21:0] cnt_q;
  reg        seen_q;
  // Shadow masks: int_o can only be judged against what the host wrote
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      m1_q   <= 8'h00;
      m2_q   <= 8'h00;
      cnt_q  <= 22'h0;
      seen_q <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == 8'h7f)
        m1_q <= wdata_i;
      if (wr_i && addr_i == 8'h6f)
        m2_q <= wdata_i;
      if (one_second_tick_o)
      begin
        cnt_q  <= {21'h0, rx_bit_en_i};
        seen_q <= 1'b1;
      end
      else
        cnt_q <= cnt_q + {21'h0, rx_bit_en_i};
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  unmapped_read_a: assert property (
    rd_i && !(addr_i inside {8'h20, 8'h21, 8'h23, 8'h24, 8'h6f, 8'h7f}) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  mask_one_a: assert property (rd_i && addr_i == 8'h7f |=> rdata_o == m1_q)
    else $error("mask one readback wrong");
  mask_two_a: assert property (rd_i && addr_i == 8'h6f |=> rdata_o == m2_q)
    else $error("mask two readback wrong");
  int_masked_a: assert property (m1_q == 8'h00 && m2_q == 8'h00 |=> !int_o)
    else $error("interrupt while all masked");
  rx_mf_int_a: assert property (rx_multiframe_i && m2_q[7] |-> ##2 int_o)
    else $error("multiframe interrupt missing");
  sync_int_a: assert property (rx_sync_loss_i && m1_q[0] |-> ##2 int_o)
    else $error("sync loss interrupt missing");
  sec_space_a: assert property (
    one_second_tick_o && seen_q |-> cnt_q == SEC_SHORT || cnt_q == SEC_LONG)
    else $error("second spacing wrong");
endmodule
bind esm_core esm_chk #(.SEC_SHORT(SEC_SHORT), .SEC_LONG(SEC_LONG)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .rx_bit_en_i(rx_bit_en_i),
  .rx_multiframe_i(rx_multiframe_i), .rx_sync_loss_i(rx_sync_loss_i),
  .one_second_tick_o(one_second_tick_o), .int_o(int_o)
);

// File: bench/esm_host.sv
// Host processor model on the parallel control port
`timescale 1ns/100ps
module esm_host (
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o,
  output reg        wr_o,
  output reg        rd_o
);
  initial
  begin
    addr_o  = 8'h55;
    wdata_o = 8'haa;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // Idle address and data are inverted so a stale value never looks valid
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk_i) #1;
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge clk_i) #1;
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge clk_i) #1;
    addr_o = a;
    rd_o   = 1'b1;
    @(posedge clk_i) #1;
    rd_o   = 1'b0;
    d      = rdata_i;
    addr_o = ~a;
  end
  endtask
  // Blue alarm is trusted only together with sync loss
  function blue_ok(input [7:0] s);
    blue_ok = s[3] & s[0];
  endfunction
endmodule

// File: bench/esm_tb.sv
// Self-checking testbench for the event status block
`timescale 1ns/100ps
module testbench;
  reg         clk_i;
  reg         rst_i;
  reg         en;
  reg         pos;
  reg         neg;
  reg         cz;
  reg         ph;
  reg         b8;
  reg         i42;
  reg         sv;
  reg         lbe;
  reg         lbd;
  reg  [15:0] ev;
  reg  [47:0] sig;
  reg  [7:0]  mv;
  reg  [7:0]  m;
  reg  [7:0]  d;
  reg  [7:0]  n;
  wire [7:0]  addr;
  wire [7:0]  wdata;
  wire        wr;
  wire        rd;
  wire [7:0]  rdata;
  wire        blue;
  wire        tick;
  wire        irq;
  integer     errors;
  integer     checks_done;
  integer     i;
  integer     k;
  esm_host h (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  esm_core #(.SEC_SHORT(30), .SEC_LONG(33), .FAST_BITS(10), .BLUE_BITS(40)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .rx_bit_en_i(en), .rx_pos_i(pos), .rx_neg_i(neg),
    .b8zs_en_i(b8), .count_zeros_i(cz), .interval_42ms_i(i42),
    .rx_multiframe_i(ev[15]), .tx_multiframe_i(ev[14]), .rx_link_bit_en_i(lbe),
    .rx_link_bit_i(lbd), .link_match_value_one_i(mv),
    .link_match_value_two_i(mv ^ 8'h0c), .tx_link_empty_i(ev[11]),
    .rx_sig_valid_i(sv), .rx_sig_bits_i(sig), .loop_up_detected_i(ev[7]),
    .loop_down_detected_i(ev[6]), .tx_clock_lost_i(ev[5]), .rx_slip_i(ev[4]),
    .rx_yellow_alarm_i(ev[2]), .line_carrier_loss_i(ev[1]),
    .rx_sync_loss_i(ev[0]), .rx_blue_alarm_o(blue), .one_second_tick_o(tick),
    .int_o(irq));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task chk(input [7:0] got, input [7:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task rc(input [7:0] a, input [7:0] e);
  begin
    h.rd(a, d);
    chk(d, e);
  end
  endtask
  task stop_test;
  begin
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task bit2(input p, input q);
  begin
    @(posedge clk_i) #1;
    en  = 1'b1;
    pos = p;
    neg = q;
    @(posedge clk_i) #1;
    en  = 1'b0;
  end
  endtask
  task mark;
  begin
    ph = ~ph;
    bit2(ph, ~ph);
  end
  endtask
  task pulse(input [3:0] j);
  begin
    @(posedge clk_i) #1;
    ev[j] = 1'b1;
    @(posedge clk_i) #1;
    ev[j] = 1'b0;
  end
  endtask
  // One event with a random mask; the event bit itself is enabled by parity of j
  task evt(input [3:0] j);
  begin
    m = $urandom;
    m[j[2:0]] = ~^j;
    h.wr(j[3] ? 8'h6f : 8'h7f, m);
    rc(j[3] ? 8'h6f : 8'h7f, m);
    pulse(j);
    repeat (2) @(posedge clk_i);
    #1 chk({7'h0, irq}, {7'h0, m[j[2:0]]});
    rc(j[3] ? 8'h21 : 8'h20, 8'h01 << j[2:0]);
    repeat (2) @(posedge clk_i);
    #1 chk({7'h0, irq}, 8'h00);
  end
  endtask
  task lbyte(input [7:0] b);
  begin
    for (k = 7; k >= 0; k = k - 1)
    begin
      @(posedge clk_i) #1;
      lbe = 1'b1;
      lbd = b[k];
    end
    @(posedge clk_i) #1;
    lbe = 1'b0;
    lbd = ~lbd;
    repeat (3) @(posedge clk_i);
  end
  endtask
  initial
  begin
    #100000;
    errors = errors + 1;
    stop_test;
  end
  initial
  begin
    {rst_i, en, pos, neg, cz, ph, b8, i42, sv, lbe, lbd} = 11'h400;
    {ev, sig, mv} = 72'h0;
    errors = 0;
    checks_done = 0;
    k = $urandom(32'hf5255398);
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rc(8'h7f, 8'h00);
    rc(8'h6f, 8'h00);
    rc(8'h22, 8'h00);
    h.wr(8'h21, 8'hff);
    rc(8'h21, 8'h00);
    for (i = 0; i < 16; i = i + 1)
      if (i < 3 || (i > 3 && i < 8) || i == 11 || i == 14 || i == 15)
        evt(i[3:0]);
    mv = $urandom & 8'h7e;
    lbyte(mv);
    rc(8'h21, 8'h14);
    lbyte(mv ^ 8'h0c);
    rc(8'h21, 8'h14);
    lbyte(8'hff);
    rc(8'h21, 8'h12);
    sig = {$urandom, $urandom};
    @(posedge clk_i) #1 sv = 1'b1;
    @(posedge clk_i) #1 sv = 1'b0;
    rc(8'h21, 8'h00);
    sig = sig ^ (48'h1 << ($urandom % 48));
    @(posedge clk_i) #1 sv = 1'b1;
    @(posedge clk_i) #1 sv = 1'b0;
    repeat (3) @(posedge clk_i);
    rc(8'h21, 8'h01);
    ev[0] = 1'b1;
    // Violations go in early so the delayed report lands inside the interval;
    // the last pass adds a substitution word that must not be counted
    for (i = 0; i < 3; i = i + 1)
    begin
      cz = (i != 0);
      b8 = (i == 2);
      while (!tick)
        mark;
      n = 1 + $urandom % 4;
      repeat (n) bit2(ph, ~ph);
      if (b8)
      begin
        repeat (3) bit2(1'b0, 1'b0);
        bit2(ph, ~ph);
        bit2(~ph, ph);
        bit2(1'b0, 1'b0);
        bit2(~ph, ph);
        bit2(ph, ~ph);
      end
      repeat (16) bit2(1'b0, 1'b0);
      while (!tick)
        mark;
      rc(8'h23, 8'h00);
      rc(8'h24, n + {7'h0, cz});
    end
    // Short interval mode: a steady violation stream fills each interval exactly
    i42 = 1'b1;
    repeat (40) bit2(1'b1, 1'b0);
    rc(8'h23, 8'h00);
    rc(8'h24, 8'h0a);
    i42 = 1'b0;
    repeat (90) mark;
    chk({7'h0, blue}, 8'h01);
    h.rd(8'h20, d);
    chk({7'h0, h.blue_ok(d)}, 8'h01);
    ev[0] = 1'b0;
    repeat (90) bit2(1'b0, 1'b0);
    chk({7'h0, blue}, 8'h00);
    rc(8'h21, 8'h20);
    stop_test;
  end
endmodule
